// >>> rtl/sfc_top.sv
/*
 * Command decode for erase-all, deep sleep, ID reads, address size and
 * error-flag clear of a serial flash.  Serial side runs on the host's
 * serial clock; state, timers and flags run on the core clock.
 * Assumes chip select stays high at least three core clocks between
 * frames, and protect bits and error set pulses come from core logic.
 */
`default_nettype none

module sfc_top
    import sfc_pkg::*;
#(
    parameter int unsigned ARRAY_ERASE_TIME_NS = 200000,
    parameter logic [7:0]  MAKER_ID  = 8'hA5,  // Arbitrary value
    parameter logic [7:0]  PART_ID   = 8'h5A,  // Arbitrary value
    parameter logic [127:0] UNIQUE_ID = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210 // Arbitrary
) (
    input  wire logic       core_clk_in,
    input  wire logic       rst_b_in,
    input  wire logic       sclk_in,
    input  wire logic       cs_b_in,
    input  wire logic       si_in,
    input  wire logic [4:0] protect_bits_in,
    input  wire logic       program_error_set_in,
    input  wire logic       erase_error_set_in,
    output logic            so_out,
    output logic            so_oe_out,
    output logic            write_in_progress_out,
    output logic            write_enable_latch_out,
    output logic            address_size_flag_out,
    output logic            program_error_flag_out,
    output logic            erase_error_flag_out,
    output logic            deep_sleep_out
);

    localparam logic [TIMER_W-1:0] ERASE_CYC =
        TIMER_W'((ARRAY_ERASE_TIME_NS * CORE_CLK_MHZ + 999) / 1000);
    localparam logic [TIMER_W-1:0] SLEEP_CYC = TIMER_W'(SLEEP_ENTRY_CYC);
    localparam logic [TIMER_W-1:0] WAKE_CYC  = TIMER_W'(WAKE_RECOVERY_CYC);
    localparam logic [TIMER_W-1:0] WAKE_ID_CYC = TIMER_W'(WAKE_ID_RECOVERY_CYC);

    // Serial clock domain

    logic [8:0]     bit_cnt_r;
    sfc_frame_t     frame_r;
    sfc_link_stat_t stat_s1_r;
    sfc_link_stat_t stat_s2_r;
    // Written on the core clock, read here only through the two stages
    sfc_link_stat_t link_stat_r;

    always_ff @(posedge sclk_in or posedge cs_b_in) begin
        if (cs_b_in) begin
            bit_cnt_r <= 9'h000;
        end else if (bit_cnt_r != BIT_COUNT_MAX) begin
            bit_cnt_r <= bit_cnt_r + 9'h001;
        end
    end

    wire new_frame = (bit_cnt_r == 9'h000);
    wire in_opcode = (bit_cnt_r < OPCODE_BITS);

    // Frame result survives chip select rising; the core reads it while
    // the serial clock is stopped, so it is quasi-static at that point.
    // opcode sampled on rising edge
    always_ff @(posedge sclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            frame_r <= '0;
        end else begin
            if (in_opcode) begin
                frame_r.opcode <= {frame_r.opcode[6:0], si_in};
            end
            frame_r.done <= (bit_cnt_r == OPCODE_BITS - 9'h001) |
                            (frame_r.done & ~new_frame);
            frame_r.over <= (bit_cnt_r == OPCODE_BITS) |
                            (frame_r.over & ~new_frame);
        end
    end

    always_ff @(posedge sclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            stat_s1_r <= '0;
            stat_s2_r <= '0;
        end else begin
            stat_s1_r <= link_stat_r;
            stat_s2_r <= stat_s1_r;
        end
    end

    wire        op_known  = ~in_opcode;
    wire        quiet     = stat_s2_r.dormant | stat_s2_r.waking;
    // wide mode adds a fifth dummy byte
    wire [8:0]  uid_start = stat_s2_r.wide ? UID_START_WIDE : UID_START_NARROW;
    wire [8:0]  uid_idx   = bit_cnt_r - uid_start;
    wire [8:0]  id_idx    = bit_cnt_r - ID_START_BITS;

    wire is_uid_op  = (frame_r.opcode == OP_UNIQUE_ID);
    wire is_dev_op  = (frame_r.opcode == OP_RELEASE_ID);
    wire is_read_maker_and_part_id_op = (frame_r.opcode == OP_MAKER_PART_ID);
    wire uid_window = (bit_cnt_r >= uid_start) & (uid_idx < 9'(UID_BITS));
    wire id_window  = (bit_cnt_r >= ID_START_BITS);
    wire link_busy  = stat_s2_r.busy | stat_s2_r.waking;

    wire rd_uid  = op_known & is_uid_op & ~quiet & uid_window;
    // release ID readout stays silent while busy or waking
    wire rd_dev  = op_known & is_dev_op & ~link_busy & id_window;
    // reads other than release stay silent asleep
    wire rd_read_maker_and_part_id = op_known & is_read_maker_and_part_id_op & ~quiet & id_window;

    wire [15:0] read_maker_and_part_id_word = {MAKER_ID, PART_ID};
    wire        uid_bit   = UNIQUE_ID[~uid_idx[6:0]];
    wire        dev_bit   = PART_ID[~id_idx[2:0]];
    wire        read_maker_and_part_id_bit  = read_maker_and_part_id_word[~id_idx[3:0]];
    wire        drive     = rd_uid | rd_dev | rd_read_maker_and_part_id;
    wire        out_bit   = rd_uid ? uid_bit : (rd_dev ? dev_bit : read_maker_and_part_id_bit);

    always_ff @(negedge sclk_in or posedge cs_b_in) begin
        if (cs_b_in) begin
            so_oe_out <= 1'b0;
        end else begin
            so_oe_out <= drive;
        end
    end

    // Data forced low when not driving, so a stale bit never leaks
    always_ff @(negedge sclk_in or posedge cs_b_in) begin
        if (cs_b_in) begin
            so_out <= 1'b0;
        end else begin
            so_out <= drive & out_bit;
        end
    end

    // Core clock domain

    logic           cs_s1_r;
    logic           cs_s2_r;
    logic           cs_s3_r;
    sfc_state_t     state_r;
    sfc_state_t     state_nxt;
    logic [TIMER_W-1:0] timer_r;
    logic [TIMER_W-1:0] timer_nxt;
    logic           wel_r;
    logic           ads_r;
    logic           pe_r;
    logic           ee_r;

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cs_s1_r <= 1'b1;
            cs_s2_r <= 1'b1;
            cs_s3_r <= 1'b1;
        end else begin
            cs_s1_r <= cs_b_in;
            cs_s2_r <= cs_s1_r;
            cs_s3_r <= cs_s2_r;
        end
    end

    wire cs_rise   = cs_s2_r & ~cs_s3_r;
    wire exact8    = frame_r.done & ~frame_r.over;
    wire [7:0] op  = frame_r.opcode;
    wire busy      = (state_r == SFC_ERASING) | pe_r | ee_r;
    wire awake     = (state_r == SFC_IDLE) | (state_r == SFC_ERASING);
    wire timer_end = (timer_r == '0);

    wire protected_any = |protect_bits_in;
    wire go_erase  = cs_rise & awake & exact8 & wel_r & ~busy & ~protected_any &
                     ((op == OP_ERASE_A) | (op == OP_ERASE_B));
    wire go_sleep  = cs_rise & awake & exact8 & ~busy & (op == OP_DEEP_SLEEP);
    wire go_wake   = cs_rise & (state_r == SFC_ASLEEP) & frame_r.done &
                     (op == OP_RELEASE_ID);
    wire go_write_enable_cmd   = cs_rise & awake & exact8 & (op == OP_WRITE_ENABLE);
    wire go_wide   = cs_rise & awake & exact8 & (op == OP_ENTER_WIDE);
    wire go_narrow = cs_rise & awake & exact8 & (op == OP_EXIT_WIDE);
    wire go_clear  = cs_rise & awake & exact8 & (op == OP_CLEAR_ERRORS);

    always_comb begin
        state_nxt = state_r;
        timer_nxt = timer_end ? timer_r : timer_r - TIMER_W'(1);
        case (state_r)
            SFC_IDLE: begin
                if (go_erase) begin
                    state_nxt = SFC_ERASING;
                    timer_nxt = ERASE_CYC - TIMER_W'(1);
                end else if (go_sleep) begin
                    state_nxt = SFC_SLEEP_WAIT;
                    timer_nxt = SLEEP_CYC - TIMER_W'(1);
                end
            end
            SFC_SLEEP_WAIT: begin
                if (timer_end) begin
                    state_nxt = SFC_ASLEEP;
                end
            end
            SFC_ASLEEP: begin
                if (go_wake) begin
                    state_nxt = SFC_WAKING;
                    timer_nxt = (frame_r.over ? WAKE_ID_CYC : WAKE_CYC) - TIMER_W'(1);
                end
            end
            SFC_WAKING: begin
                if (timer_end) begin
                    state_nxt = SFC_IDLE;
                end
            end
            SFC_ERASING: begin
                if (timer_end) begin
                    state_nxt = SFC_IDLE;
                end
            end
            default: begin
                state_nxt = SFC_IDLE;
                timer_nxt = '0;
            end
        endcase
    end

    // Set wins over clear for both error flags
    // clear error flags
    wire pe_nxt  = program_error_set_in | (pe_r & ~go_clear);
    wire ee_nxt  = erase_error_set_in | (ee_r & ~go_clear);
    wire wel_nxt = go_write_enable_cmd | (wel_r & ~go_erase);
    wire ads_nxt = go_wide | (ads_r & ~go_narrow);
    wire wip_nxt = (state_nxt == SFC_ERASING) | pe_nxt | ee_nxt;

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_r <= SFC_IDLE;
            timer_r <= '0;
        end else begin
            state_r <= state_nxt;
            timer_r <= timer_nxt;
        end
    end

    // reset selects narrow addresses
    // Kept apart from the state so sleep and wake leave them alone
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wel_r <= 1'b0;
            ads_r <= 1'b0;
        end else begin
            wel_r <= wel_nxt;
            ads_r <= ads_nxt;
        end
    end

    // Error flags hold the device busy until the clear opcode
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pe_r <= 1'b0;
            ee_r <= 1'b0;
        end else begin
            pe_r <= pe_nxt;
            ee_r <= ee_nxt;
        end
    end

    // Outputs load from the same next values as the internal flops,
    // so the status pins never lag the internal copy by a cycle
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            write_in_progress_out  <= 1'b0;
            write_enable_latch_out <= 1'b0;
            address_size_flag_out  <= 1'b0;
        end else begin
            write_in_progress_out  <= wip_nxt;
            write_enable_latch_out <= wel_nxt;
            address_size_flag_out  <= ads_nxt;
        end
    end

    // Error and sleep outputs
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            program_error_flag_out <= 1'b0;
            erase_error_flag_out   <= 1'b0;
            deep_sleep_out         <= 1'b0;
        end else begin
            program_error_flag_out <= pe_nxt;
            erase_error_flag_out   <= ee_nxt;
            deep_sleep_out         <= (state_nxt == SFC_ASLEEP);
        end
    end

    // Status for the serial side; sleep pending counts as dormant so
    // reads other than release stay silent from the moment the sleep opcode is taken
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            link_stat_r            <= '0;
        end else begin
            link_stat_r.busy       <= wip_nxt;
            link_stat_r.wide       <= ads_nxt;
            link_stat_r.dormant    <= (state_nxt == SFC_ASLEEP) |
                                      (state_nxt == SFC_SLEEP_WAIT);
            link_stat_r.waking     <= (state_nxt == SFC_WAKING);
        end
    end

endmodule
`default_nettype wire

// >>> rtl/sfc_pkg.sv
/*
 * Shared constants and carriers for the serial flash command block:
 * opcodes, status bit positions, frame lengths, timing figures.
 * Assumes a 25 MHz core clock; the serial clock is a separate domain.
 */
`default_nettype none
package sfc_pkg;

    localparam int unsigned CORE_CLK_MHZ = 25;

    // Opcodes handled here
    localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
    localparam logic [7:0] OP_ERASE_A       = 8'h60;
    localparam logic [7:0] OP_ERASE_B       = 8'hC7;
    localparam logic [7:0] OP_DEEP_SLEEP    = 8'hB9;
    localparam logic [7:0] OP_UNIQUE_ID     = 8'h4B;
    localparam logic [7:0] OP_ENTER_WIDE    = 8'hB7;
    localparam logic [7:0] OP_EXIT_WIDE     = 8'hE9;
    localparam logic [7:0] OP_CLEAR_ERRORS  = 8'h30;
    localparam logic [7:0] OP_RELEASE_ID    = 8'hAB;
    localparam logic [7:0] OP_MAKER_PART_ID = 8'h90;

    // Status register bit positions of the flags kept here
    localparam int unsigned ADDRESS_SIZE_BIT  = 13;
    localparam int unsigned PROGRAM_ERROR_BIT = 21;
    localparam int unsigned ERASE_ERROR_BIT   = 22;

    // Frame lengths in serial clock bits
    localparam logic [8:0] OPCODE_BITS    = 9'h008;
    localparam logic [8:0] ID_START_BITS  = 9'h020;
    localparam logic [8:0] UID_START_NARROW = 9'h028;
    localparam logic [8:0] UID_START_WIDE   = 9'h030;
    localparam logic [8:0] BIT_COUNT_MAX  = 9'h1FF;
    localparam int unsigned UID_BITS      = 128;

    // Timing figures in ns and their cycle counts (least times round up)
    localparam int unsigned SLEEP_ENTRY_DELAY_NS     = 3000;
    localparam int unsigned WAKE_RECOVERY_TIME_NS    = 8000;
    localparam int unsigned WAKE_ID_RECOVERY_TIME_NS = 8000;
    localparam int unsigned SLEEP_ENTRY_CYC =
        (SLEEP_ENTRY_DELAY_NS * CORE_CLK_MHZ + 999) / 1000;
    localparam int unsigned WAKE_RECOVERY_CYC =
        (WAKE_RECOVERY_TIME_NS * CORE_CLK_MHZ + 999) / 1000;
    localparam int unsigned WAKE_ID_RECOVERY_CYC =
        (WAKE_ID_RECOVERY_TIME_NS * CORE_CLK_MHZ + 999) / 1000;

    localparam int unsigned TIMER_W = 24;

    // Power and cycle state, Gray coded along idle-sleep-wake
    typedef enum logic [2:0] {
        SFC_IDLE       = 3'b000,
        SFC_SLEEP_WAIT = 3'b001,
        SFC_ASLEEP     = 3'b011,
        SFC_WAKING     = 3'b010,
        SFC_ERASING    = 3'b100
    } sfc_state_t;

    // Frame result held in the serial domain after chip select rises
    typedef struct packed {
        logic [7:0] opcode;
        logic       done;
        logic       over;
    } sfc_frame_t;

    // Core state seen by the serial domain
    typedef struct packed {
        logic busy;
        logic wide;
        logic dormant;
        logic waking;
    } sfc_link_stat_t;

endpackage
`default_nettype wire

// >>> tb/sfc_chk.sv
/*
 * Port-level assertions for sfc_top, bound at the foot of this file.
 * Assumes all checks sample on the core clock; chip select seen as a level.
 */
`default_nettype none
module sfc_chk
    import sfc_pkg::*;
(
    input wire logic       core_clk_in,
    input wire logic       rst_b_in,
    input wire logic       cs_b_in,
    input wire logic [4:0] protect_bits_in,
    input wire logic       so_oe_out,
    input wire logic       write_in_progress_out,
    input wire logic       write_enable_latch_out,
    input wire logic       address_size_flag_out,
    input wire logic       program_error_flag_out,
    input wire logic       erase_error_flag_out,
    input wire logic       deep_sleep_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic       ds_q_r;
    logic [8:0] wake_cnt_r;
    logic [8:0] wake_cnt_nxt;
    logic [7:0] cs_cnt_r;
    logic [7:0] cs_cnt_nxt;

    // Saturating, so a long idle spell never wraps into a short count
    assign wake_cnt_nxt = (ds_q_r && !deep_sleep_out) ? 9'h000 :
                          (wake_cnt_r == 9'h1FF) ? wake_cnt_r : wake_cnt_r + 9'h001;
    assign cs_cnt_nxt = !cs_b_in ? 8'h00 : (cs_cnt_r == 8'hFF) ? cs_cnt_r : cs_cnt_r + 8'h01;

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ds_q_r     <= 1'b0;
            wake_cnt_r <= 9'h1FF;
            cs_cnt_r   <= 8'h00;
        end else begin
            ds_q_r     <= deep_sleep_out;
            wake_cnt_r <= wake_cnt_nxt;
            cs_cnt_r   <= cs_cnt_nxt;
        end
    end

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_b_in);

    AST_SO_IDLE: assert property (cs_b_in |-> !so_oe_out)
        else $error("output enabled while deselected");
    AST_RESET_START: assert property ($rose(rst_b_in) |-> !deep_sleep_out
        && !address_size_flag_out && !write_in_progress_out && !write_enable_latch_out)
        else $error("flags not clear after reset");
    AST_ERASE_START: assert property ($rose(write_in_progress_out)
        && !program_error_flag_out && !erase_error_flag_out |-> $past(write_enable_latch_out)
        && !write_enable_latch_out && $past(protect_bits_in) == 5'h00)
        else $error("erase start without latch or with protection");
    AST_SLEEP_DELAY: assert property ($rose(deep_sleep_out) |->
        cs_cnt_r >= SLEEP_ENTRY_CYC && cs_cnt_r <= SLEEP_ENTRY_CYC + 8)
        else $error("sleep entry delay off");
    AST_SLEEP_IDLE: assert property ($rose(deep_sleep_out) |-> !write_in_progress_out)
        else $error("sleep entered while busy");
    AST_ASLEEP_FROZEN: assert property (deep_sleep_out && $past(deep_sleep_out) |->
        $stable(write_enable_latch_out) && $stable(address_size_flag_out))
        else $error("status changed while asleep");
    AST_WAKE_RECOV: assert property ($rose(write_enable_latch_out)
        || $rose(address_size_flag_out) |-> wake_cnt_r >= WAKE_RECOVERY_CYC)
        else $error("command taken during wake recovery");
    AST_ERR_BUSY: assert property (program_error_flag_out || erase_error_flag_out
        |-> ##[0:1] write_in_progress_out)
        else $error("error flag set but not busy");
    AST_CLEAR_KEEPS_WEL: assert property ($fell(program_error_flag_out) |->
        $stable(write_enable_latch_out))
        else $error("error clear changed the latch");
endmodule

bind sfc_top sfc_chk u_chk (.core_clk_in, .rst_b_in, .cs_b_in, .protect_bits_in, .so_oe_out,
    .write_in_progress_out, .write_enable_latch_out, .address_size_flag_out,
    .program_error_flag_out, .erase_error_flag_out, .deep_sleep_out);
`default_nettype wire

// >>> tb/sfc_host.sv
/*
 * Host controller model: frames with chip select, serial clock, data in.
 * Assumes clock idles low and a pull-up on the data-out line.
 */
`default_nettype none
module sfc_host (
    output logic     sclk_out,
    output logic     cs_b_out,
    output logic     si_out,
    input wire logic so_in,
    input wire logic so_oe_in
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        sclk_out = 1'b0;
        cs_b_out = 1'b1;
        si_out   = 1'b0;
    end

    task automatic xfer(input logic [7:0] op, input int nb, input logic [63:0] tail,
                        output logic [127:0] rd);
        logic [127:0] w;
        w = {op, tail, 56'h0};
        rd = '0;
        cs_b_out = 1'b0;
        #5;
        // Clock runs only inside a frame
        repeat (nb) begin
            si_out = w[127];
            w = w << 1;
            #7.5 sclk_out = 1'b1;
            rd = {rd[126:0], so_oe_in ? so_in : 1'b1};
            #7.5 sclk_out = 1'b0;
        end
        #5 cs_b_out = 1'b1;
        // Released line shows the inverse, never a stale bit
        si_out = ~si_out;
        #200;
    endtask
endmodule
`default_nettype wire

// >>> tb/tb.sv
/*
 * Self-checking bench for sfc_top: host model frames, queued result checks.
 * Assumes sfc_host on the serial pins and sfc_chk bound to the design.
 */
`default_nettype none
`define CHK(e, g) begin exp_q.push_back(128'(e)); got_r = 128'(g); -> res_ev; #1; end
module tb
    import sfc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [7:0]   MK  = 8'h3C;  // Arbitrary value
    localparam logic [7:0]   PT  = 8'hC3;  // Arbitrary value
    localparam logic [127:0] UID = 128'h1F2E_3D4C_5B6A_7988_96A5_B4C3_D2E1_F00F; // Arbitrary
    logic         clk, rst_b, sclk, cs_b, si, pes, ees, so, so_oe;
    logic         write_in_progress, write_enable_latch, address_size_flag, pef, eef, ds;
    logic [4:0]   pb;
    logic [5:0]   st;
    logic [63:0]  rnd;
    logic [127:0] rd, got_r;
    logic [127:0] exp_q[$];
    int           seed, mismatches, total_checks;
    event         res_ev;

    assign st = {write_in_progress, write_enable_latch, address_size_flag, pef, eef, ds};

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    sfc_host host (.sclk_out(sclk), .cs_b_out(cs_b), .si_out(si), .so_in(so), .so_oe_in(so_oe));
    sfc_top #(.ARRAY_ERASE_TIME_NS(20000), .MAKER_ID(MK), .PART_ID(PT), .UNIQUE_ID(UID)) DUT (
        .core_clk_in(clk), .rst_b_in(rst_b), .sclk_in(sclk), .cs_b_in(cs_b), .si_in(si),
        .protect_bits_in(pb), .program_error_set_in(pes), .erase_error_set_in(ees),
        .so_out(so), .so_oe_out(so_oe), .write_in_progress_out(write_in_progress),
        .write_enable_latch_out(write_enable_latch), .address_size_flag_out(address_size_flag),
        .program_error_flag_out(pef), .erase_error_flag_out(eef), .deep_sleep_out(ds));

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic cmd(input logic [7:0] op, input int nb = 8);
        host.xfer(op, nb, rnd, rd);
        tick(1);
    endtask
    // Keeps only the last n samples, the data phase
    task automatic rdx(input logic [7:0] op, input int pre, input int n, input logic [63:0] t);
        host.xfer(op, pre + n, t, rd);
        rd = rd & ((128'h1 << n) - 128'h1);
        tick(1);
    endtask
    task automatic complete_run();
        if (mismatches == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial forever begin
        @(res_ev);
        total_checks++;
        if (exp_q.pop_front() !== got_r) begin
            mismatches++;
            $display("[ERR] %0t result mismatch, got %h", $time, got_r);
        end
    end

    initial begin
        #1000000;
        mismatches++;
        $display("[ERR] %0t run did not finish", $time);
        complete_run();
    end

    initial begin
        seed = 34;
        rst_b = 1'b0;
        pb = 5'h00;
        pes = 1'b0;
        ees = 1'b0;
        rnd = {$random(seed), $random(seed)};
        tick(16);
        rst_b = 1'b1;
        tick(2);
        `CHK(6'h00, st)
        cmd(OP_ERASE_A);
        `CHK(6'h00, st)
        cmd(OP_WRITE_ENABLE);
        for (int n = 7; n <= 9; n += 2) begin
            cmd(OP_ERASE_B, n);
            `CHK(6'h10, st)
        end
        for (int i = 0; i < 5; i++) begin
            pb = 5'(1 << i) | 5'($random(seed));
            cmd(OP_ERASE_A);
            `CHK(6'h10, st)
        end
        pb = 5'h00;
        for (int i = 0; i < 2; i++) begin
            rnd = {$random(seed), $random(seed)};
            cmd(OP_WRITE_ENABLE);
            cmd(i == 0 ? OP_ERASE_A : OP_ERASE_B);
            `CHK(6'h20, st)
            cmd(OP_DEEP_SLEEP);
            tick(90);
            `CHK(6'h20, st)
            rdx(OP_RELEASE_ID, 32, 16, rnd);
            `CHK(16'hFFFF, rd)
            for (int k = 0; k < 1000 && write_in_progress === 1'b1; k++) tick(1);
            `CHK(6'h00, st)
        end
        cmd(OP_WRITE_ENABLE);
        pes = 1'b1;
        ees = 1'b1;
        tick(1);
        pes = 1'b0;
        ees = 1'b0;
        tick(4);
        `CHK(6'h36, st)
        cmd(OP_CLEAR_ERRORS);
        `CHK(6'h10, st)
        cmd(OP_ENTER_WIDE);
        `CHK(6'h18, st)
        rdx(OP_UNIQUE_ID, 48, 128, rnd);
        `CHK(UID, rd)
        cmd(OP_EXIT_WIDE);
        `CHK(6'h10, st)
        rdx(OP_UNIQUE_ID, 40, 128, rnd);
        `CHK(UID, rd)
        rdx(OP_MAKER_PART_ID, 32, 16, 64'h0);
        `CHK({MK, PT}, rd)
        rdx(OP_RELEASE_ID, 32, 16, rnd);
        `CHK({PT, PT}, rd)
        cmd(OP_DEEP_SLEEP, 9);
        tick(90);
        `CHK(6'h10, st)
        cmd(OP_DEEP_SLEEP);
        tick(SLEEP_ENTRY_CYC);
        `CHK(6'h11, st)
        cmd(OP_ERASE_A);
        cmd(OP_ENTER_WIDE);
        `CHK(6'h11, st)
        rdx(OP_MAKER_PART_ID, 32, 16, 64'h0);
        `CHK(16'hFFFF, rd)
        cmd(OP_RELEASE_ID);
        cmd(OP_ENTER_WIDE);
        `CHK(6'h10, st)
        tick(WAKE_RECOVERY_CYC);
        cmd(OP_ENTER_WIDE);
        `CHK(6'h18, st)
        cmd(OP_DEEP_SLEEP);
        tick(SLEEP_ENTRY_CYC);
        rdx(OP_RELEASE_ID, 32, 16, rnd);
        `CHK({PT, PT}, rd)
        `CHK(6'h18, st)
        tick(WAKE_ID_RECOVERY_CYC);
        cmd(OP_DEEP_SLEEP);
        tick(SLEEP_ENTRY_CYC);
        `CHK(6'h19, st)
        rst_b = 1'b0;
        tick(3);
        rst_b = 1'b1;
        tick(2);
        `CHK(6'h00, st)
        tick(4);
        complete_run();
    end
endmodule
`default_nettype wire
